// *** rss_defs.vh ***
// Constants for the reset and start-up sequencer.
// Assumes a 250 MHz ref_clk; included by bare name.
`ifndef RSS_DEFS_VH
`define RSS_DEFS_VH
// Power-up delay, milliseconds, and its RC tick count
`define RSS_PWRUP_MS 72
`define RSS_RC_KHZ 32
`define RSS_PWRUP_TICKS (`RSS_PWRUP_MS * `RSS_RC_KHZ)
// Oscillator start-up count, oscillator input cycles
`define RSS_OST_CYCLES 1024
// Brown-out dip filter, nanoseconds, and derived ref_clk cycles
`define RSS_CLK_NS 4
`define RSS_BOR_MIN_NS 100000
`define RSS_BOR_CYCLES ((`RSS_BOR_MIN_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
// Oscillator mode encodings
`define RSS_MODE_LP 2'h0
`define RSS_MODE_XT 2'h1
`define RSS_MODE_HS 2'h2
`define RSS_MODE_RC 2'h3
`endif

// *** rss_edge_count.v ***
// Counts rising edges of a sampled slow input up to a terminal value.
// Assumes edge_in is already synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module rss_edge_count #(
    parameter WIDTH = 12,
    parameter [WIDTH-1:0] TERMINAL = 12'h400
) (
    // Clock and reset
    input wire ref_clk,
    input wire reset_n,
    // Control
    input wire clear,
    input wire run,
    input wire edge_in,
    // Status
    output wire done
);
    reg [WIDTH-1:0] count_reg;
    reg [WIDTH-1:0] count_next;
    reg prev_reg;

    assign done = (count_reg == TERMINAL);

    always @*
    begin
        count_next = count_reg;
        if (clear)
            count_next = {WIDTH{1'b0}};
        else if (run && !done && edge_in && !prev_reg)
            count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end

    always @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_reg <= {WIDTH{1'b0}};
            prev_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            prev_reg <= edge_in;
        end
    end
endmodule
`default_nettype wire

// *** rss_reset_startup_sequencer.v ***
// Reset and start-up sequencer: power-on pulse, power-up timer,
// oscillator start-up timer and brown-out reset.
// Assumes analog comparators give por_detect and supply_low, and that
// the RC oscillator and oscillator input are sampled on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "rss_defs.vh"

module rss_reset_startup_sequencer #(
    parameter PWRUP_TICKS = `RSS_PWRUP_TICKS,
    parameter BOR_CYCLES = `RSS_BOR_CYCLES
) (
    // Clock and reset
    input wire ref_clk,
    input wire reset_n,
    // Analog monitors
    input wire por_detect,
    input wire supply_low,
    // Clock sources
    input wire rc_osc,
    input wire oscillator_input,
    // Configuration
    input wire power_up_timer_enable,
    input wire brown_out_enable_bit,
    input wire [1:0] osc_mode,
    // Wake-up from sleep
    input wire wake_from_sleep,
    // Status
    output reg chip_reset,
    output reg brown_out_reset,
    output reg power_up_timer_active,
    output reg oscillator_startup_timer_active
);
    localparam ST_POR = 3'h0;
    localparam ST_BOR = 3'h1;
    localparam ST_POWER_UP_TIMER = 3'h2;
    localparam ST_OST = 3'h3;
    localparam ST_RUN = 3'h4;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [31:0] power_up_timer_reg;
    reg [31:0] power_up_timer_next;
    reg [31:0] dip_reg;
    reg [31:0] dip_next;
    reg rc_prev_reg;
    reg ost_needed_reg;
    reg ost_needed_next;
    wire rc_tick;
    wire bor_trip;
    wire power_up_timer_done;
    wire ost_done;
    wire ost_clear;
    wire crystal_mode;

    assign rc_tick = rc_osc && !rc_prev_reg;
    assign power_up_timer_done = (power_up_timer_reg == PWRUP_TICKS);
    // Brown-out only when enabled, and only once the dip outlasts the filter
    assign bor_trip = brown_out_enable_bit
        && (dip_reg == BOR_CYCLES);
    assign crystal_mode = (osc_mode == `RSS_MODE_XT)
        || (osc_mode == `RSS_MODE_LP)
        || (osc_mode == `RSS_MODE_HS);
    // Held clear outside the count, so a wake-up count starts from zero
    assign ost_clear = (state_reg != ST_OST);

    rss_edge_count #(
        .WIDTH(12),
        .TERMINAL(12'h400)
    ) u_ost (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clear(ost_clear),
        .run(state_reg == ST_OST),
        .edge_in(oscillator_input),
        .done(ost_done)
    );

    always @*
    begin
        dip_next = dip_reg;
        if (!supply_low)
            dip_next = 32'h0;
        else if (dip_reg != BOR_CYCLES)
            dip_next = dip_reg + 32'h1;
    end

    always @*
    begin
        state_next = state_reg;
        ost_needed_next = ost_needed_reg;
        case (state_reg)
            ST_POR:
                if (!por_detect)
                begin
                    state_next = ST_POWER_UP_TIMER;
                    ost_needed_next = crystal_mode;
                end
            ST_BOR:
                if (!supply_low)
                    state_next = ST_POWER_UP_TIMER;
            ST_POWER_UP_TIMER:
                if (!power_up_timer_enable || power_up_timer_done)
                    state_next = ost_needed_reg ? ST_OST : ST_RUN;
            ST_OST:
                if (ost_done)
                    state_next = ST_RUN;
            ST_RUN:
                if (wake_from_sleep && crystal_mode)
                begin
                    state_next = ST_OST;
                    ost_needed_next = 1'b1;
                end
            default:
                state_next = ST_POR;
        endcase
        // Power-on and brown-out take priority over every state
        if (por_detect)
            state_next = ST_POR;
        else if (bor_trip)
            state_next = ST_BOR;
    end

    always @*
    begin
        power_up_timer_next = power_up_timer_reg;
        if (state_next != ST_POWER_UP_TIMER || state_reg != ST_POWER_UP_TIMER)
            power_up_timer_next = 32'h0;
        else if (rc_tick && !power_up_timer_done)
            power_up_timer_next = power_up_timer_reg + 32'h1;
    end

    always @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= ST_POR;
            power_up_timer_reg <= 32'h0;
            dip_reg <= 32'h0;
            rc_prev_reg <= 1'b0;
            ost_needed_reg <= 1'b0;
            chip_reset <= 1'b1;
            brown_out_reset <= 1'b0;
            power_up_timer_active <= 1'b0;
            oscillator_startup_timer_active <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            power_up_timer_reg <= power_up_timer_next;
            dip_reg <= dip_next;
            rc_prev_reg <= rc_osc;
            ost_needed_reg <= ost_needed_next;
            // Wake-up start-up wait asserts chip_reset too, like every state but run
            chip_reset <= (state_next != ST_RUN);
            brown_out_reset <= (state_next == ST_BOR);
            power_up_timer_active <= (state_next == ST_POWER_UP_TIMER);
            oscillator_startup_timer_active <= (state_next == ST_OST);
        end
    end
endmodule
`default_nettype wire

// *** rss_checker_sva.sv ***
// Assertions on the reset and start-up sequencer ports.
// Bound into every instance of the sequencer top.
`timescale 1ns/1ps
`default_nettype none
module rss_checker_sva #(
    parameter PWRUP_TICKS = 4,
    parameter BOR_CYCLES = 3
) (
    // Clock and reset
    input wire ref_clk,
    input wire reset_n,
    // Monitors and configuration
    input wire por_detect,
    input wire supply_low,
    input wire brown_out_enable_bit,
    input wire [1:0] osc_mode,
    // Status
    input wire chip_reset,
    input wire brown_out_reset,
    input wire power_up_timer_active,
    input wire oscillator_startup_timer_active
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Two low cycles, shorter than any filter this bench uses
    sequence short_dip_s;
        !supply_low ##1 supply_low [*2] ##1 !supply_low;
    endsequence
    por_clear_a: assert property (por_detect |=> chip_reset &&
        !power_up_timer_active && !oscillator_startup_timer_active)
        else $error("power-on did not clear the timers");
    power_up_timer_hold_a: assert property (power_up_timer_active |-> chip_reset)
        else $error("reset dropped while power-up timer runs");
    ost_hold_a: assert property (oscillator_startup_timer_active |->
        chip_reset && !power_up_timer_active)
        else $error("start-up count not holding reset");
    release_a: assert property (!chip_reset |->
        !brown_out_reset && !power_up_timer_active)
        else $error("reset released too early");
    bor_off_a: assert property (!brown_out_enable_bit && !brown_out_reset
        |=> !brown_out_reset)
        else $error("brown-out while disabled");
    dip_pass_a: assert property (!brown_out_reset ##0 short_dip_s
        |=> !brown_out_reset)
        else $error("short dip caused brown-out");
    bor_exit_a: assert property ($fell(brown_out_reset) &&
        !$past(por_detect) |-> power_up_timer_active)
        else $error("no power-up delay after brown-out");
    rc_no_ost_a: assert property ($fell(power_up_timer_active) &&
        osc_mode == 2'h3 |-> !oscillator_startup_timer_active)
        else $error("start-up count in RC mode");
endmodule
bind rss_reset_startup_sequencer rss_checker_sva #(
    .PWRUP_TICKS(PWRUP_TICKS), .BOR_CYCLES(BOR_CYCLES)) u_rss_checker_sva (
    .ref_clk, .reset_n, .por_detect, .supply_low, .brown_out_enable_bit,
    .osc_mode, .chip_reset, .brown_out_reset, .power_up_timer_active,
    .oscillator_startup_timer_active);
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the reset and start-up sequencer.
// Drives all inputs; short timer counts keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk = 0, reset_n = 0, por = 1, low = 0, rc = 0, osc = 0;
    logic rc_en = 1, pte = 1, boe = 1, wake = 0, cr, bor, pta, osta;
    logic [1:0] mode = 2'h1;
    int failures = 0, cmp_count = 0;
    rss_reset_startup_sequencer #(.PWRUP_TICKS(4), .BOR_CYCLES(3))
        u_rss_reset_startup_sequencer (.ref_clk(ref_clk), .reset_n(reset_n),
        .por_detect(por), .supply_low(low), .rc_osc(rc),
        .oscillator_input(osc), .power_up_timer_enable(pte),
        .brown_out_enable_bit(boe), .osc_mode(mode),
        .wake_from_sleep(wake), .chip_reset(cr), .brown_out_reset(bor),
        .power_up_timer_active(pta), .oscillator_startup_timer_active(osta));
    always #2 ref_clk = ~ref_clk;
    // RC can stall so a frozen power-up count shows
    always @(posedge ref_clk)
    begin
        osc <= ~osc;
        if (rc_en)
            rc <= ~rc;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(input logic c);
        cmp_count++;
        if (c !== 1'b1)
        begin
            failures++;
            $display("mismatch at %0t: wrong status", $time);
        end
    endtask
    // Cycles each phase holds before release, bounded
    task automatic run_out(output int pw, output int os);
        pw = 0;
        os = 0;
        for (int i = 0; i < 3000 && cr !== 1'b0; i++)
        begin
            cyc(1);
            pw += pta;
            os += osta;
        end
    endtask
    task automatic power_on(input logic [1:0] m, input logic p);
        int pw;
        int os;
        mode <= m;
        pte <= p;
        por <= 1;
        cyc(3);
        chk(cr === 1'b1);
        por <= 0;
        run_out(pw, os);
        chk(cr === 1'b0);
        chk(p ? pw >= 6 && pw <= 12 : pw <= 1);
        chk(m == 2'h3 ? os == 0 : os >= 2044 && os <= 2056);
        $display("power-on test done");
    endtask
    task automatic brown_out;
        pte <= 1;
        low <= 1;
        cyc(2);
        low <= 0;
        cyc(3);
        chk(bor === 1'b0 && cr === 1'b0);
        low <= 1;
        cyc(6);
        chk(bor === 1'b1 && cr === 1'b1);
        low <= 0;
        cyc(3);
        chk(pta === 1'b1);
        low <= 1;
        cyc(6);
        chk(bor === 1'b1 && pta === 1'b0);
        low <= 0;
        rc_en <= 0;
        cyc(30);
        chk(pta === 1'b1);
        rc_en <= 1;
        cyc(20);
        chk(cr === 1'b0);
        boe <= 0;
        low <= 1;
        cyc(10);
        chk(bor === 1'b0 && cr === 1'b0);
        low <= 0;
        $display("brown-out test done");
    endtask
    task automatic wake_up;
        int pw;
        int os;
        mode <= 2'h1;
        wake <= 1;
        cyc(1);
        wake <= 0;
        cyc(3);
        chk(osta === 1'b1 && cr === 1'b1);
        run_out(pw, os);
        chk(cr === 1'b0 && os >= 2040 && os <= 2056);
        mode <= 2'h3;
        wake <= 1;
        cyc(1);
        wake <= 0;
        cyc(3);
        chk(osta === 1'b0 && cr === 1'b0);
        $display("wake test done");
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        cyc(2);
        reset_n <= 1;
        for (int m = 0; m < 4; m++)
            power_on(m[1:0], 1'b1);
        power_on(2'h3, 1'b0);
        brown_out();
        wake_up();
        print_verdict();
    end
    initial
    begin
        #200000;
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
